// ---- scm_pkg.sv ----
// constants and types shared by the sensor correction math block
package scm_pkg;

   // ****************************************************************
   // command codes
   // ****************************************************************
   localparam logic [7:0]  CMD_MEAS_LO  = 8'hAA;
   localparam logic [7:0]  CMD_MEAS_HI  = 8'hAF;
   localparam logic [7:0]  CMD_PRIMARY  = 8'hB0;
   localparam logic [7:0]  CMD_ALTERN   = 8'hB1;

   // ****************************************************************
   // nonvolatile addresses and reset values of the setup words, reset value of the result words
   // ****************************************************************
   localparam logic [7:0]  ADDR_PRIMARY = 8'h12;
   localparam logic [7:0]  ADDR_ALTERN  = 8'h16;
   localparam logic [15:0] SETUP_RESET  = 16'h0000;
   localparam logic [23:0] WORD_RESET   = 24'h00_0000;

   // ****************************************************************
   // arithmetic constants
   // ****************************************************************
   localparam logic [4:0]         SHIFT_0    = 5'd0;
   localparam logic [4:0]         SHIFT_21   = 5'd21;
   localparam logic [4:0]         SHIFT_23   = 5'd23;
   localparam logic signed [27:0] ADD_ZERO   = 28'sh000_0000;
   localparam logic signed [27:0] ADD_2P23   = 28'sh080_0000;
   localparam logic signed [25:0] UNITY      = 26'sh000_0001;
   localparam logic signed [25:0] SIGNED_MAX = 26'sh1FF_FFFF;
   localparam logic signed [25:0] SIGNED_MIN = 26'sh200_0000;
   localparam logic signed [25:0] UNS25_MAX  = 26'sh1FF_FFFF;
   localparam logic signed [25:0] UNS24_MAX  = 26'sh0FF_FFFF;
   localparam logic signed [25:0] VAL_ZERO   = 26'sh000_0000;
   localparam logic [0:0]         STAT_SAT_BIT = 1'd0;

   // ****************************************************************
   // sequencer
   // ****************************************************************
   localparam logic [3:0] STEP_FIRST = 4'd0;
   localparam logic [3:0] STEP_LAST  = 4'd12;

   typedef enum logic [1:0] {
      CLAMP_S26 = 2'b00,
      CLAMP_U25 = 2'b01,
      CLAMP_U24 = 2'b10
   } scm_clamp_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN  = 2'b01,
      ST_DONE = 2'b10
   } scm_state_t;

endpackage

// ---- scm_link_if.sv ----
// internal link between the sequencer, the multiply-add unit and setup
interface scm_link_if;
   import scm_pkg::*;

   logic signed [25:0] op_a;
   logic signed [25:0] op_b;
   logic signed [27:0] op_c;
   logic [4:0]         shift;
   scm_clamp_t         mode;
   logic signed [25:0] result;
   logic               sat;

   logic               cmd_valid;
   logic [7:0]         cmd_code;
   logic               wr_en;
   logic [7:0]         wr_addr;
   logic [15:0]        wr_data;
   logic               alt_sel;
   logic [15:0]        setup_word;

   modport mac_unit (input op_a, op_b, op_c, shift, mode,
                     output result, sat);
   modport mac_user (output op_a, op_b, op_c, shift, mode,
                     input result, sat);
   modport sel_unit (input cmd_valid, cmd_code, wr_en, wr_addr, wr_data,
                     output alt_sel, setup_word);
   modport sel_user (output cmd_valid, cmd_code, wr_en, wr_addr, wr_data,
                     input alt_sel, setup_word);
endinterface

// ---- scm_mac.sv ----
// shared signed multiply, shift, clamp, add and clamp unit
module scm_mac (
   scm_link_if.mac_unit lk   // operands in, clamped result out
);
   import scm_pkg::*;

   logic signed [51:0] prod;
   logic signed [51:0] shifted;
   logic               prod_sat;
   logic signed [25:0] prod_cl;
   logic signed [28:0] sum;
   logic               sum_sat;
   logic signed [25:0] sum_cl;

   assign prod     = lk.op_a * lk.op_b;
   assign shifted  = prod >>> lk.shift;
   assign prod_sat = !((&shifted[51:25]) | (~|shifted[51:25]));
   assign prod_cl  = prod_sat ? (shifted[51] ? SIGNED_MIN : SIGNED_MAX)
                              : shifted[25:0];
   assign sum      = 29'(prod_cl) + 29'(lk.op_c);

   always_comb begin
      sum_sat = 1'b0;
      sum_cl  = sum[25:0];
      case (lk.mode)
         CLAMP_S26: begin
            sum_sat = !((&sum[28:25]) | (~|sum[28:25]));
            if (sum_sat) begin
               sum_cl = sum[28] ? SIGNED_MIN : SIGNED_MAX;
            end
         end
         CLAMP_U25: begin
            sum_sat = sum[28] | (|sum[27:25]);
            if (sum_sat) begin
               sum_cl = sum[28] ? VAL_ZERO : UNS25_MAX;
            end
         end
         CLAMP_U24: begin
            sum_sat = sum[28] | (|sum[27:24]);
            if (sum_sat) begin
               sum_cl = sum[28] ? VAL_ZERO : UNS24_MAX;
            end
         end
         default: begin
            sum_sat = 1'b0;
            sum_cl  = sum[25:0];
         end
      endcase
   end

   assign lk.result = sum_cl;
   assign lk.sat = prod_sat | sum_sat;
endmodule // scm_mac

// ---- scm_setup_sel.sv ----
// holds the two analog setup words and the active selection
module scm_setup_sel (
   input  wire logic    clk_sys,  // system clock
   input  wire logic    rst_n,    // asynchronous reset, active low
   scm_link_if.sel_unit lk        // commands and writes in, setup out
);
   import scm_pkg::*;

   logic [15:0] primary_ff;
   logic [15:0] alternate_ff;
   logic        alt_sel_ff;
   logic        wr_primary;
   logic        wr_alternate;
   logic        cmd_alt;
   logic        cmd_pri;

   assign wr_primary   = lk.wr_en && (lk.wr_addr == ADDR_PRIMARY);
   assign wr_alternate = lk.wr_en && (lk.wr_addr == ADDR_ALTERN);
   assign cmd_alt      = lk.cmd_valid && (lk.cmd_code == CMD_ALTERN);
   assign cmd_pri      = lk.cmd_valid && (lk.cmd_code == CMD_PRIMARY);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         primary_ff   <= SETUP_RESET;
         alternate_ff <= SETUP_RESET;
         alt_sel_ff   <= 1'b0;
      end else begin
         if (wr_primary) begin
            primary_ff <= lk.wr_data;
         end
         if (wr_alternate) begin
            alternate_ff <= lk.wr_data;
         end
         if (cmd_alt) begin
            alt_sel_ff <= 1'b1;
         end else if (cmd_pri) begin
            alt_sel_ff <= 1'b0;
         end
      end
   end

   assign lk.alt_sel    = alt_sel_ff;
   assign lk.setup_word = alt_sel_ff ? alternate_ff : primary_ff;
endmodule // scm_setup_sel

// ---- scm_core.sv ----
// sensor and temperature correction datapath with setup selection
//
// Notes on behaviour
// - shift coefficient added to final result
// - commands AA to AF return corrected results
// - primary setup at 12h, alternate at 16h
// - primary default; B1 alternate, B0 primary
// - any reset returns selection to primary
// - alternate without valid coefficients passes raw sensor through, temperature still corrected
// - saturation still gives result, sets status bit 0
// - intermediates clamped to signed 26-bit range
// - curve select: 0 parabolic, 1 S-shaped
// - gain-drift factor from second-order gain drift
// - offset term from offset, raw, offset drift
// - parabolic intermediate: gain times factor times offset
// - parabolic output clamped to 0..2^24-1
// - S-shape uses absolute intermediate, adds 2^23 last
// - temperature always parabolic
// - temperature intermediate clamped to 0..2^25-1
// - corrected temperature clamped to 0..2^24-1
// - all results are 24-bit words
// - raw results two's complement, bit 23 negative
// - corrected sensor output unsigned 0..FFFFFF
// - raw sensor input is signed auto-zero reading
module scm_core (
   input  wire logic        clk_sys,          // system clock, 10 MHz
   input  wire logic        rst_n,            // async reset, active low
   input  wire logic        cmd_valid,        // host command strobe
   input  wire logic [7:0]  cmd_code,         // host command code
   input  wire logic        mem_wr_en,        // setup word write strobe
   input  wire logic [7:0]  mem_wr_addr,      // setup word address
   input  wire logic [15:0] mem_wr_data,      // setup word data
   input  wire logic [23:0] raw_sensor,       // auto-zeroed sensor reading
   input  wire logic [23:0] raw_temp,         // auto-zeroed temperature
   input  wire logic        alt_coeff_valid,  // coefficients fit alternate
   input  wire logic        sensor_curve_select, // 0 parabolic, 1 s-shape
   input  wire logic [23:0] gain_s,           // sensor gain
   input  wire logic [23:0] offset_s,         // sensor offset
   input  wire logic [23:0] tcg,              // gain drift
   input  wire logic [23:0] tco,              // offset drift
   input  wire logic [23:0] gain_drift_second_order,   // 2nd order tcg
   input  wire logic [23:0] offset_drift_second_order, // 2nd order tco
   input  wire logic [23:0] sensor_second_order,       // 2nd order sensor
   input  wire logic [23:0] sens_shift,       // post-assembly sensor shift
   input  wire logic [23:0] gain_t,           // temperature gain
   input  wire logic [23:0] offset_t,         // temperature offset
   input  wire logic [23:0] temperature_second_order,  // 2nd order temp
   input  wire logic [23:0] t_shift,          // post-assembly temp shift
   output logic             busy,             // measurement in progress
   output logic             result_valid,     // one-cycle result strobe
   output logic [23:0]      sensor_out,       // corrected sensor word
   output logic [23:0]      temp_out,         // corrected temperature word
   output logic [7:0]       status,           // status byte, bit 0 sat
   output logic             alt_selected,     // alternate setup active
   output logic [15:0]      active_setup      // setup word in use
);
   import scm_pkg::*;

   // ****************************************************************
   // internal link and submodules
   // ****************************************************************
   scm_link_if lk ();

   scm_mac u_mac (
      .lk (lk.mac_unit)
   );

   scm_setup_sel u_sel (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .lk      (lk.sel_unit)
   );

   assign lk.cmd_valid = cmd_valid;
   assign lk.cmd_code  = cmd_code;
   assign lk.wr_en     = mem_wr_en;
   assign lk.wr_addr   = mem_wr_addr;
   assign lk.wr_data   = mem_wr_data;

   // ****************************************************************
   // state
   // ****************************************************************
   scm_state_t         state_ff;
   scm_state_t         nxt_state;
   logic [3:0]         step_ff;
   logic               curve_ff;
   logic               pass_ff;
   logic               sat_ff;
   logic signed [25:0] rs_ff;
   logic signed [25:0] rt_ff;
   logic signed [25:0] x_ff;
   logic signed [25:0] k1_ff;
   logic signed [25:0] k2_ff;
   logic signed [25:0] p_ff;
   logic signed [25:0] z_ff;
   logic signed [25:0] zt_ff;
   logic signed [25:0] s_ff;
   logic               busy_ff;
   logic               valid_ff;
   logic [23:0]        sensor_ff;
   logic [23:0]        temp_ff;
   logic [7:0]         status_ff;
   logic               alt_ff;
   logic [15:0]        setup_ff;

   // ****************************************************************
   // decode
   // ****************************************************************
   logic               meas_cmd;
   logic               start;
   logic               last_step;
   logic signed [25:0] z_mag;
   logic signed [25:0] z_second;
   logic signed [27:0] s_final_add;
   logic signed [27:0] s_base_add;
   logic [23:0]        sensor_word;

   assign meas_cmd  = cmd_valid && (cmd_code >= CMD_MEAS_LO)
                      && (cmd_code <= CMD_MEAS_HI);
   assign start     = meas_cmd && (state_ff == ST_IDLE);
   assign last_step = (step_ff == STEP_LAST);
   // magnitude of the most negative value wraps; z_ff can also hold it from
   // an unsaturated step 6 result, so the status bit is not always set then
   assign z_mag     = z_ff[25] ? -z_ff : z_ff;
   assign z_second  = curve_ff ? z_mag : z_ff;
   assign s_base_add  = curve_ff ? ADD_ZERO : ADD_2P23;
   assign s_final_add = (curve_ff ? ADD_2P23 : ADD_ZERO)
                        + 28'(signed'(sens_shift));
   assign sensor_word = pass_ff ? rs_ff[23:0] : s_ff[23:0];

   // ****************************************************************
   // operand selection per step
   // ****************************************************************
   // operands depend on step_ff, and on curve_ff in steps 6 to 8, so the one multiply-add unit
   // serves all thirteen steps without any arbitration
   always_comb begin
      lk.op_a  = UNITY;
      lk.op_b  = VAL_ZERO;
      lk.op_c  = ADD_ZERO;
      lk.shift = SHIFT_0;
      lk.mode  = CLAMP_S26;
      case (step_ff)
         4'd0: begin
            lk.op_a  = 26'(signed'(gain_drift_second_order));
            lk.op_b  = rt_ff;
            lk.shift = SHIFT_21;
            lk.op_c  = 28'(signed'({tcg, 2'b00}));
         end
         4'd1: begin
            lk.op_a  = rt_ff;
            lk.op_b  = x_ff;
            lk.shift = SHIFT_23;
            lk.op_c  = ADD_2P23;
         end
         4'd2: begin
            lk.op_a  = 26'(signed'(offset_drift_second_order));
            lk.op_b  = rt_ff;
            lk.shift = SHIFT_21;
            lk.op_c  = 28'(signed'({tco, 2'b00}));
         end
         4'd3: begin
            lk.op_a  = rt_ff;
            lk.op_b  = x_ff;
            lk.shift = SHIFT_23;
            lk.op_c  = 28'(rs_ff);
         end
         4'd4: begin
            lk.op_b  = k2_ff;
            lk.op_c  = 28'(signed'({offset_s, 2'b00}));
         end
         4'd5: begin
            lk.op_a  = k1_ff;
            lk.op_b  = k2_ff;
            lk.shift = SHIFT_23;
         end
         4'd6: begin
            lk.op_a  = 26'(signed'(gain_s));
            lk.op_b  = p_ff;
            lk.shift = SHIFT_21;
            lk.op_c  = s_base_add;
         end
         4'd7: begin
            lk.op_a  = 26'(signed'(sensor_second_order));
            lk.op_b  = z_second;
            lk.shift = SHIFT_21;
            lk.op_c  = ADD_2P23;
         end
         4'd8: begin
            lk.op_a  = z_ff;
            lk.op_b  = x_ff;
            lk.shift = SHIFT_23;
            lk.op_c  = s_final_add;
            lk.mode  = CLAMP_U24;
         end
         4'd9: begin
            lk.op_b  = rt_ff;
            lk.op_c  = 28'(signed'({offset_t, 2'b00}));
         end
         4'd10: begin
            lk.op_a  = 26'(signed'(gain_t));
            lk.op_b  = x_ff;
            lk.shift = SHIFT_21;
            lk.op_c  = ADD_2P23;
            lk.mode  = CLAMP_U25;
         end
         4'd11: begin
            lk.op_a  = 26'(signed'(temperature_second_order));
            lk.op_b  = zt_ff;
            lk.shift = SHIFT_21;
            lk.op_c  = ADD_2P23;
         end
         4'd12: begin
            lk.op_a  = zt_ff;
            lk.op_b  = x_ff;
            lk.shift = SHIFT_23;
            lk.op_c  = 28'(signed'(t_shift));
            lk.mode  = CLAMP_U24;
         end
         default: begin
            lk.op_a  = UNITY;
            lk.op_b  = VAL_ZERO;
         end
      endcase
   end

   // ****************************************************************
   // sequencer
   // ****************************************************************
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (start) begin
               nxt_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (last_step) begin
               nxt_state = ST_DONE;
            end
         end
         ST_DONE: begin
            nxt_state = ST_IDLE;
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= ST_IDLE;
         step_ff  <= STEP_FIRST;
         curve_ff <= 1'b0;
         pass_ff  <= 1'b0;
         sat_ff   <= 1'b0;
         rs_ff    <= VAL_ZERO;
         rt_ff    <= VAL_ZERO;
      end else begin
         state_ff <= nxt_state;
         // measurement codes are only taken while idle: a strobe during a
         // run is dropped, never queued
         if (start) begin
            step_ff  <= STEP_FIRST;
            curve_ff <= sensor_curve_select;
            pass_ff  <= lk.alt_sel && !alt_coeff_valid;
            sat_ff   <= 1'b0;
            rs_ff    <= 26'(signed'(raw_sensor));
            rt_ff    <= 26'(signed'(raw_temp));
         end else if (state_ff == ST_RUN) begin
            step_ff <= step_ff + 4'd1;
            sat_ff  <= sat_ff | lk.sat;
         end
      end
   end

   // ****************************************************************
   // intermediate storage
   // ****************************************************************
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         x_ff  <= VAL_ZERO;
         k1_ff <= VAL_ZERO;
         k2_ff <= VAL_ZERO;
         p_ff  <= VAL_ZERO;
         z_ff  <= VAL_ZERO;
         zt_ff <= VAL_ZERO;
         s_ff  <= VAL_ZERO;
      end else if (state_ff == ST_RUN) begin
         case (step_ff)
            // results of steps 1, 3 to 6, 8 and 10 keep their own register; the
            // rest land in x_ff, read by the very next step except after step 12
            4'd1:    k1_ff <= lk.result;
            4'd3:    k2_ff <= lk.result;
            4'd4:    k2_ff <= lk.result;
            4'd5:    p_ff  <= lk.result;
            4'd6:    z_ff  <= lk.result;
            4'd8:    s_ff  <= lk.result;
            4'd10:   zt_ff <= lk.result;
            default: x_ff  <= lk.result;
         endcase
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         busy_ff   <= 1'b0;
         valid_ff  <= 1'b0;
         sensor_ff <= WORD_RESET;
         temp_ff   <= WORD_RESET;
         status_ff <= 8'h00;
         alt_ff    <= 1'b0;
         setup_ff  <= SETUP_RESET;
      end else begin
         busy_ff  <= (nxt_state != ST_IDLE);
         valid_ff <= last_step && (state_ff == ST_RUN);
         alt_ff   <= lk.alt_sel;
         setup_ff <= lk.setup_word;
         if (last_step && (state_ff == ST_RUN)) begin
            sensor_ff <= sensor_word;
            temp_ff   <= lk.result[23:0];
            // sat_ff lags by one step, so the last step is folded in here
            status_ff <= 8'h00;
            status_ff[STAT_SAT_BIT] <= sat_ff | lk.sat;
         end
      end
   end

   assign busy         = busy_ff;
   assign result_valid = valid_ff;
   assign sensor_out   = sensor_ff;
   assign temp_out     = temp_ff;
   assign status       = status_ff;
   assign alt_selected = alt_ff;
   assign active_setup = setup_ff;
endmodule // scm_core

// ---- scm_core_assertions.sv ----
// port assertions for the sensor correction datapath
module scm_core_chk
   import scm_pkg::*;
(
   input wire logic        clk_sys,      // system clock
   input wire logic        rst_n,        // async reset, active low
   input wire logic        cmd_valid,    // command strobe
   input wire logic [7:0]  cmd_code,     // command code
   input wire logic        busy,         // measurement running
   input wire logic        result_valid, // result strobe
   input wire logic [23:0] sensor_out,   // corrected sensor
   input wire logic [23:0] temp_out,     // corrected temperature
   input wire logic [7:0]  status,       // status byte
   input wire logic        alt_selected  // alternate active
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   wire go = cmd_valid && !busy && cmd_code >= CMD_MEAS_LO
             && cmd_code <= CMD_MEAS_HI;
   result_latency_a: assert property (go |-> ##14 result_valid)
      else $error("no result 14 cycles after command");
   busy_hold_a: assert property (go |=> busy [*8])
      else $error("busy dropped early");
   valid_pulse_a: assert property (result_valid |=> !result_valid)
      else $error("result strobe longer than one cycle");
   valid_end_a: assert property (result_valid |-> busy ##1 !busy)
      else $error("busy wrong around result");
   output_hold_a: assert property (!result_valid |->
      $stable(sensor_out) && $stable(temp_out))
      else $error("outputs changed without result strobe");
   status_spare_a: assert property (status[7:1] == 7'h00)
      else $error("unused status bits set");
   alt_select_a: assert property (cmd_valid && cmd_code == CMD_ALTERN
      |-> ##2 alt_selected)
      else $error("alternate not selected");
   primary_select_a: assert property (cmd_valid && cmd_code == CMD_PRIMARY
      |-> ##2 !alt_selected)
      else $error("primary not selected");
endmodule // scm_core_chk

bind scm_core scm_core_chk u_chk (.clk_sys, .rst_n, .cmd_valid, .cmd_code,
   .busy, .result_valid, .sensor_out, .temp_out, .status, .alt_selected);

// ---- scm_host.sv ----
// host model issuing commands and setup writes
module scm_host (
   input  wire logic   clk_sys,     // system clock
   output logic        cmd_valid,   // command strobe
   output logic [7:0]  cmd_code,    // command code
   output logic        mem_wr_en,   // write strobe
   output logic [7:0]  mem_wr_addr, // write address
   output logic [15:0] mem_wr_data  // write data
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      {cmd_valid, mem_wr_en} = 2'h0;
      {cmd_code, mem_wr_addr, mem_wr_data} = 32'h0000_0000;
   end
   // selection is sent before the alternate measurement and resent after the second reset
   task automatic cmd(input logic [7:0] c);
      @(negedge clk_sys);
      cmd_valid = 1'h1;
      cmd_code  = c;
      @(negedge clk_sys);
      cmd_valid = 1'h0;
      cmd_code  = ~c;
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge clk_sys);
      mem_wr_en   = 1'h1;
      mem_wr_addr = a;
      mem_wr_data = d;
      @(negedge clk_sys);
      mem_wr_en   = 1'h0;
      mem_wr_addr = ~a;
      mem_wr_data = ~d;
   endtask
endmodule // scm_host

// ---- sensor_correction_math_bench.sv ----
// self-checking bench for the sensor correction datapath
module sensor_correction_math_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import scm_pkg::*;
   localparam longint P23 = 1 << 23;
   localparam longint L25 = 1 << 25;
   logic        clk_sys = 1'h0, rst_n = 1'h0, alt_cv = 1'h1, curve = 1'h0;
   logic        cmd_valid, mem_wr_en, busy, result_valid, alt_selected;
   logic [7:0]  cmd_code, mem_wr_addr, status;
   logic [15:0] mem_wr_data, active_setup;
   logic [23:0] sensor_out, temp_out;
   longint      k[12], rs = 0, rt = 0;
   bit          sat;
   int          n_errors = 0, checked = 0, j;
   always #50 clk_sys = ~clk_sys;
   scm_host host (.clk_sys, .cmd_valid, .cmd_code, .mem_wr_en,
      .mem_wr_addr, .mem_wr_data);
   scm_core dut (.clk_sys, .rst_n, .cmd_valid, .cmd_code, .mem_wr_en,
      .mem_wr_addr, .mem_wr_data, .raw_sensor(rs[23:0]),
      .raw_temp(rt[23:0]), .alt_coeff_valid(alt_cv),
      .sensor_curve_select(curve), .gain_s(k[0][23:0]),
      .offset_s(k[1][23:0]), .tcg(k[2][23:0]), .tco(k[3][23:0]),
      .gain_drift_second_order(k[4][23:0]),
      .offset_drift_second_order(k[5][23:0]),
      .sensor_second_order(k[6][23:0]), .sens_shift(k[7][23:0]),
      .gain_t(k[8][23:0]), .offset_t(k[9][23:0]),
      .temperature_second_order(k[10][23:0]), .t_shift(k[11][23:0]),
      .busy, .result_valid, .sensor_out, .temp_out, .status,
      .alt_selected, .active_setup);
   // clamp that notes any change as saturation
   function automatic longint cl(longint v, longint lo = -L25,
                                 longint hi = L25 - 1);
      if (v > hi || v < lo)
         sat = 1'h1;
      return (v > hi) ? hi : (v < lo) ? lo : v;
   endfunction
   function automatic longint m(longint a, longint b, int s);
      return cl((a * b) >>> s);
   endfunction
   function automatic void calc(bit cv, output longint s, output longint t);
      longint x, k1, k2, z;
      x  = cl(m(k[4], rt, 21) + 4 * k[2]);
      k1 = cl(m(rt, x, 23) + P23);
      x  = cl(m(k[5], rt, 21) + 4 * k[3]);
      k2 = cl(cl(m(rt, x, 23) + rs) + 4 * k[1]);
      z  = cl(m(k[0], m(k1, k2, 23), 21) + (cv ? 0 : P23));
      x  = cl(m(k[6], (cv && z < 0) ? -z : z, 21) + P23);
      s  = cl(m(z, x, 23) + (cv ? P23 : 0) + k[7], 0, P23 * 2 - 1);
      x  = cl(rt + 4 * k[9]);
      z  = cl(m(k[8], x, 21) + P23, 0, L25 - 1);
      x  = cl(m(k[10], z, 21) + P23);
      t  = cl(m(z, x, 23) + k[11], 0, P23 * 2 - 1);
   endfunction
   task automatic chk(string n, logic [23:0] v, logic [23:0] e);
      checked++;
      if (v !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", n, e, v);
      end
   endtask
   task automatic meas(logic [7:0] c, bit cv, bit pass, bit rf);
      longint s, t;
      int     i;
      sat = 1'h0;
      calc(cv, s, t);
      curve = cv;
      if (pass)
         s = rs;
      host.cmd(c);
      if (rf) begin
         rs = rs + 7;
         host.cmd(c);
      end
      for (i = 0; i < 20 && result_valid !== 1'h1; i++)
         @(negedge clk_sys);
      chk("valid", result_valid, 1'h1);
      chk("sensor", sensor_out, s[23:0]);
      chk("temp", temp_out, t[23:0]);
      chk("status", status, {7'h00, sat});
   endtask
   task automatic summarize();
      if (n_errors == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #1_000_000;
      n_errors++;
      summarize();
   end
   initial begin
      k = '{2000000, 10000, 3000, -2000, 50000, -40000, -300000, 0,
            1900000, 5000, 200000, 0};
      repeat (5) @(negedge clk_sys);
      rst_n = 1'h1;
      chk("reset sel", alt_selected, 1'h0);
      for (j = 0; j < 6; j++) begin
         rs = 2000 - j * 1500;
         rt = j * 3000 - 7000;
         meas(8'(CMD_MEAS_LO + j), j[0], 0, 0);
      end
      k[7]  = -1234;
      k[11] = 4321;
      meas(8'hAE, 1'h0, 0, 1);
      k[0] = 8388607;
      k[1] = 4194303;
      rs   = 8388607;
      meas(CMD_MEAS_HI, 1'h0, 0, 0);
      k[0] = 2000000;
      k[1] = 10000;
      rs   = -5000;
      host.wr(ADDR_PRIMARY, 16'h1234);
      host.wr(ADDR_ALTERN, 16'hABCD);
      host.wr(8'h14, 16'h5555);
      chk("setup", active_setup, 16'h1234);
      host.cmd(CMD_ALTERN);
      @(negedge clk_sys);
      chk("alt sel", alt_selected, 1'h1);
      chk("alt setup", active_setup, 16'hABCD);
      alt_cv = 1'h0;
      meas(8'hAB, 1'h0, 1, 0);
      rst_n = 1'h0;
      repeat (2) @(negedge clk_sys);
      rst_n = 1'h1;
      chk("sel after reset", alt_selected, 1'h0);
      chk("setup after reset", active_setup, 16'h0000);
      host.cmd(CMD_ALTERN);
      @(negedge clk_sys);
      chk("reissued sel", alt_selected, 1'h1);
      host.cmd(CMD_PRIMARY);
      @(negedge clk_sys);
      chk("primary sel", alt_selected, 1'h0);
      summarize();
   end
endmodule // sensor_correction_math_bench
